/* File: design/pccs_command_status.sv */
/*
 * Command and status register (bits 23..0 plus the status byte, write-one-to-clear except its fixed DEVSEL timing field)
 * with its control outputs and parity error signalling.
 * Assumes the configuration decoder presents one-cycle read/write strobes on this clock,
 * and that pins (strap, bus parity error) arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
module pccs_command_status
	import pccs_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_cfg_wr,
	input  wire logic        i_cfg_rd,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [31:0] i_cfg_wdata,
	output logic      [31:0] o_cfg_rdata,
	input  wire logic        i_eeprom_load_on,
	input  wire logic        i_eeprom_ext_cap,
	input  wire logic        i_eeprom_done,
	input  wire logic        i_ext_cap_strap,
	input  wire logic        i_master_parity_error_select,
	input  wire logic        i_target_addr_par_err,
	input  wire logic        i_target_data_par_err,
	input  wire logic        i_master_data_par_err,
	input  wire logic        i_perr_pin_n,
	input  wire logic        i_master_req,
	input  wire logic        i_mem_hit,
	input  wire logic        i_io_hit,
	output logic             o_master_grant_ok,
	output logic             o_mem_claim,
	output logic             o_io_claim,
	output logic             o_cap_regs_on,
	output logic             o_back_to_back_allow,
	output logic             o_serr_n_oe,
	output logic             o_perr_n_oe,
	output logic             o_initiator_perr_seen
);
	////////////////////////////////////////////////////////////////////////////
	logic [31:0] cmd_q, cmd_d;
	logic        ext_cap_q, ext_cap_d;
	logic        loaded_q, loaded_d;
	logic [7:0]  stat_q, stat_d;
	logic [2:0]  perr_sync_q;
	logic [2:0]  strap_sync_q;
	logic [2:0]  strap_fill_q;
	logic        perr_seen_q, perr_seen_d;
	logic [31:0] rdata_d;
	logic        serr_d, perr_d;
	logic        par_on, hit_wr;

	// The bus PERR pin and the strap are asynchronous: three stages, second and third agree.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			perr_sync_q  <= 3'h7;
			strap_sync_q <= 3'h0;
			strap_fill_q <= 3'h0;
		end else begin
			perr_sync_q  <= {perr_sync_q[1:0], i_perr_pin_n};
			strap_sync_q <= {strap_sync_q[1:0], i_ext_cap_strap};
			// The fill marker keeps the reset zeros of the chain from being taken as the strap.
			strap_fill_q <= {strap_fill_q[1:0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		par_on  = cmd_q[PCCS_BIT_PAR_RESP];
		hit_wr  = i_cfg_wr && (i_cfg_addr == PCCS_CS_OFFSET);
		cmd_d   = cmd_q;
		if (hit_wr) begin
			cmd_d = i_cfg_wdata & PCCS_CMD_WR_MASK;
		end
		// The strap is taken once after release, never under reset itself.
		ext_cap_d = ext_cap_q;
		loaded_d  = loaded_q;
		if (!loaded_q) begin
			if (i_eeprom_load_on) begin
				if (i_eeprom_done) begin
					ext_cap_d = i_eeprom_ext_cap;
					loaded_d  = 1'b1;
				end
			end else if (strap_fill_q[2] && (strap_sync_q[2] == strap_sync_q[1])) begin
				ext_cap_d = strap_sync_q[2];
				loaded_d  = 1'b1;
			end
		end
		serr_d = cmd_q[PCCS_BIT_SERR_ON] && par_on && (i_target_addr_par_err
			|| (i_master_data_par_err && !i_master_parity_error_select));
		perr_d = par_on && i_target_data_par_err;
		perr_seen_d = perr_seen_q;
		if (i_master_req && par_on && (perr_sync_q[2] == perr_sync_q[1])) begin
			perr_seen_d = !perr_sync_q[2];
		end else if (!par_on) begin
			perr_seen_d = 1'b0;
		end
		// Status events win over a write-one clear in the same cycle.
		stat_d = stat_q;
		if (hit_wr) begin
			stat_d = stat_q & ~i_cfg_wdata[31:24];
		end
		if (serr_d) begin
			stat_d[PCCS_BIT_SIG_SERR-24] = 1'b1;
		end
		if (par_on && (i_target_data_par_err || i_master_data_par_err)) begin
			stat_d[PCCS_BIT_DET_PAR-24] = 1'b1;
		end
		if (par_on && i_master_data_par_err) begin
			stat_d[PCCS_BIT_DATA_PAR-24] = 1'b1;
		end
		stat_d[PCCS_DEVSEL_LSB-24 +: 2] = PCCS_DEVSEL_TIMING;
		rdata_d = o_cfg_rdata;
		if (i_cfg_rd) begin
			rdata_d = '0;
			if (i_cfg_addr == PCCS_CS_OFFSET) begin
				rdata_d = cmd_q & PCCS_CMD_WR_MASK;
				rdata_d[31:24] = stat_q;
				rdata_d[PCCS_BIT_B2B_CAP] = 1'b1;
				rdata_d[PCCS_BIT_EXT_CAP] = ext_cap_q;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cmd_q                 <= PCCS_CMD_RESET;
			ext_cap_q             <= 1'b0;
			loaded_q              <= 1'b0;
			stat_q                <= {5'h0, PCCS_DEVSEL_TIMING, 1'b0};
			perr_seen_q           <= 1'b0;
			o_cfg_rdata           <= '0;
			o_master_grant_ok     <= 1'b0;
			o_mem_claim           <= 1'b0;
			o_io_claim            <= 1'b0;
			o_cap_regs_on         <= 1'b0;
			o_back_to_back_allow  <= 1'b0;
			o_serr_n_oe           <= 1'b1;
			o_perr_n_oe           <= 1'b1;
			o_initiator_perr_seen <= 1'b0;
		end else begin
			cmd_q                 <= cmd_d;
			ext_cap_q             <= ext_cap_d;
			loaded_q              <= loaded_d;
			stat_q                <= stat_d;
			perr_seen_q           <= perr_seen_d;
			o_cfg_rdata           <= rdata_d;
			o_master_grant_ok     <= i_master_req && cmd_q[PCCS_BIT_MASTER];
			o_mem_claim           <= i_mem_hit && cmd_q[PCCS_BIT_MEM_ON];
			o_io_claim            <= i_io_hit && cmd_q[PCCS_BIT_IO_ON];
			o_cap_regs_on         <= ext_cap_q;
			o_back_to_back_allow  <= cmd_q[PCCS_BIT_B2B_ALLOW];
			o_serr_n_oe           <= !serr_d;
			o_perr_n_oe           <= !perr_d;
			o_initiator_perr_seen <= perr_seen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chk_b2b_reads_one: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_cfg_rd && i_cfg_addr == PCCS_CS_OFFSET |=> o_cfg_rdata[PCCS_BIT_B2B_CAP])
		else $error("Back-to-back capable bit read as zero.");
	chk_cap_follows_bit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		##1 o_cap_regs_on == $past(ext_cap_q))
		else $error("Capability enable does not follow the capability bit.");
	chk_cap_off_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!ext_cap_q ##1 !ext_cap_q |-> !o_cap_regs_on)
		else $error("Capability registers on while the bit is clear.");
	chk_strap_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!loaded_q && !i_eeprom_load_on && strap_fill_q[2] && strap_sync_q[2] == strap_sync_q[1]
		|=> loaded_q && ext_cap_q == $past(strap_sync_q[2]))
		else $error("Strap value not taken.");
	chk_eeprom_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!loaded_q && i_eeprom_load_on && i_eeprom_done
		|=> loaded_q && ext_cap_q == $past(i_eeprom_ext_cap))
		else $error("EEPROM capability value not taken.");
	chk_serr_addr: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_target_addr_par_err && cmd_q[PCCS_BIT_SERR_ON] && cmd_q[PCCS_BIT_PAR_RESP]
		|=> !o_serr_n_oe ##1 stat_q[PCCS_BIT_SIG_SERR-24])
		else $error("SERR missing on address parity error.");
	chk_serr_master: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_master_data_par_err && i_master_parity_error_select && !i_target_addr_par_err
		|=> o_serr_n_oe)
		else $error("SERR driven with master select set.");
	chk_perr_target: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_target_data_par_err && cmd_q[PCCS_BIT_PAR_RESP] |=> !o_perr_n_oe)
		else $error("PERR missing on target data parity error.");
	chk_par_off_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!cmd_q[PCCS_BIT_PAR_RESP] |=> o_perr_n_oe && o_serr_n_oe)
		else $error("Parity signalling while response is off.");
	chk_master_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!cmd_q[PCCS_BIT_MASTER] |=> !o_master_grant_ok)
		else $error("Mastering while bus master bit is clear.");
	chk_mem_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_mem_claim |-> $past(cmd_q[PCCS_BIT_MEM_ON]) && $past(i_mem_hit))
		else $error("Memory claim without enable.");
	chk_io_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_io_claim |-> $past(cmd_q[PCCS_BIT_IO_ON]) && $past(i_io_hit))
		else $error("I/O claim without enable.");
	chk_w1c_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		hit_wr && i_cfg_wdata[PCCS_BIT_SIG_SERR] && !serr_d |=> !stat_q[PCCS_BIT_SIG_SERR-24])
		else $error("Signalled error bit not cleared by write one.");
	chk_unused_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_cfg_rd |=> (o_cfg_rdata & 32'h006f_fcb8) == 32'h0)
		else $error("Unused bit read as one.");
	cov_serr: cover property (@(posedge i_ref_clk) disable iff (i_srst) !o_serr_n_oe);
	cov_perr: cover property (@(posedge i_ref_clk) disable iff (i_srst) !o_perr_n_oe);
	cov_master: cover property (@(posedge i_ref_clk) disable iff (i_srst) o_master_grant_ok);
	cov_eeprom: cover property (@(posedge i_ref_clk) disable iff (i_srst)
		!loaded_q && i_eeprom_load_on && i_eeprom_done);
	cov_clear: cover property (@(posedge i_ref_clk) disable iff (i_srst)
		stat_q[PCCS_BIT_SIG_SERR-24] ##1 hit_wr ##1 !stat_q[PCCS_BIT_SIG_SERR-24]);
endmodule : pccs_command_status
`default_nettype wire

/* File: design/pccs_pkg.sv */
/*
 * Constants for the PCI configuration command and status register block.
 * Assumes a single 25 MHz clock domain and a synchronous active-high reset.
 */
package pccs_pkg;
	localparam logic [7:0]  PCCS_CS_OFFSET      = 8'h04;
	localparam int          PCCS_BIT_IO_ON      = 0;
	localparam int          PCCS_BIT_MEM_ON     = 1;
	localparam int          PCCS_BIT_MASTER     = 2;
	localparam int          PCCS_BIT_PAR_RESP   = 6;
	localparam int          PCCS_BIT_SERR_ON    = 8;
	localparam int          PCCS_BIT_B2B_ALLOW  = 9;
	localparam int          PCCS_BIT_EXT_CAP    = 20;
	localparam int          PCCS_BIT_B2B_CAP    = 23;
	localparam int          PCCS_BIT_DATA_PAR   = 24;
	localparam int          PCCS_BIT_SIG_SERR   = 30;
	localparam int          PCCS_BIT_DET_PAR    = 31;
	localparam logic [31:0] PCCS_CMD_WR_MASK    = 32'h0000_0347;
	localparam logic [31:0] PCCS_STAT_W1C_MASK  = 32'hff00_0000;
	localparam logic [31:0] PCCS_CMD_RESET      = 32'h0000_0000;
	localparam logic [1:0]  PCCS_DEVSEL_TIMING  = 2'h1;
	localparam int          PCCS_DEVSEL_LSB     = 25;
endpackage : pccs_pkg

/* File: tb/pccs_host_model.sv */
/* Configuration host model: issues single register writes and reads.
   Assumes the bench supplies the block clock and waits for reset to end. */
`timescale 1ns/1ps
`default_nettype none
module pccs_host_model (
	input  wire logic        i_ref_clk,
	input  wire logic [31:0] i_rdata,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [7:0]  o_addr,
	output logic      [31:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 32'h0000_0000;
	end
	// Released data is inverted so a stale bus never looks valid.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge i_ref_clk);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_ref_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = ~d;
		@(negedge i_ref_clk);
		q = i_rdata;
	endtask : acc
endmodule : pccs_host_model
`default_nettype wire

/* File: tb/testbench.sv */
/* Self-checking bench for the command and status register block.
   Assumes the host model for config traffic and a strap-loaded capability bit. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pccs_pkg::*;
	logic        clk, srst, wr, rd, sel, a_err, d_err, m_err, perr_n, req, mhit, ihit;
	logic [7:0]  addr;
	logic [31:0] wd, rdat, q;
	logic        mg, mc, ic, cap, b2b, serr_oe, perr_oe, iseen;
	logic        eload, ecap, edone, strap;
	int          n_errors, num_checks, cyc;
	pccs_host_model host_u (.i_ref_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wd));
	pccs_command_status dut_u (.i_ref_clk(clk), .i_srst(srst), .i_cfg_wr(wr),
		.i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wd), .o_cfg_rdata(rdat),
		.i_eeprom_load_on(eload), .i_eeprom_ext_cap(ecap), .i_eeprom_done(edone),
		.i_ext_cap_strap(strap), .i_master_parity_error_select(sel),
		.i_target_addr_par_err(a_err), .i_target_data_par_err(d_err),
		.i_master_data_par_err(m_err), .i_perr_pin_n(perr_n), .i_master_req(req),
		.i_mem_hit(mhit), .i_io_hit(ihit), .o_master_grant_ok(mg), .o_mem_claim(mc),
		.o_io_claim(ic), .o_cap_regs_on(cap), .o_back_to_back_allow(b2b),
		.o_serr_n_oe(serr_oe), .o_perr_n_oe(perr_oe), .o_initiator_perr_seen(iseen));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic final_report;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// One error pulse, then count how many cycles each pin enable is driven.
	task automatic err(input int k, input int es, input int ep);
		int ns, np;
		ns = 0;
		np = 0;
		@(negedge clk);
		{m_err, d_err, a_err} = 3'h1 << k;
		@(negedge clk);
		{m_err, d_err, a_err} = 3'h0;
		repeat (3) begin
			ns += int'(serr_oe === 1'b0);
			np += int'(perr_oe === 1'b0);
			@(negedge clk);
		end
		cmp("serr cycles", es, ns);
		cmp("perr cycles", ep, np);
	endtask : err
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("reset value", 32'h0290_0000, q);
		cmp("cap on", 32'h1, {31'h0, cap});
		host_u.acc(1'b1, PCCS_CS_OFFSET, 32'hffff_ffff, q);
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("all ones", 32'h0290_0347, q);
		cmp("b2b allow", 32'h1, {31'h0, b2b});
		host_u.acc(1'b0, 8'h08, 32'h0, q);
		cmp("other addr", 32'h0, q);
	endtask : t_reset
	task automatic t_claims(input logic [31:0] c);
		host_u.acc(1'b1, PCCS_CS_OFFSET, c, q);
		repeat (2) @(negedge clk);
		cmp("claims", {29'h0, c[2:0]}, {29'h0, mg, mc, ic});
	endtask : t_claims
	task automatic t_parity;
		host_u.acc(1'b1, PCCS_CS_OFFSET, 32'h0000_0100, q);
		err(0, 0, 0);
		err(1, 0, 0);
		host_u.acc(1'b1, PCCS_CS_OFFSET, 32'hff00_0140, q);
		err(0, 1, 0);
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("status set", 32'h4290_0140, q);
		host_u.acc(1'b1, PCCS_CS_OFFSET, 32'hc000_0140, q);
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("status clear", 32'h0290_0140, q);
		err(1, 0, 1);
		sel = 1'b1;
		err(2, 0, 0);
		sel = 1'b0;
		err(2, 1, 0);
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("status all", 32'hc390_0140, q);
	endtask : t_parity
	task automatic t_initiator;
		host_u.acc(1'b1, PCCS_CS_OFFSET, 32'h0000_0144, q);
		perr_n = 1'b0;
		repeat (8) @(negedge clk);
		perr_n = 1'b1;
		cmp("initiator perr", 32'h1, {31'h0, iseen});
		repeat (5) @(negedge clk);
		cmp("initiator idle", 32'h0, {31'h0, iseen});
	endtask : t_initiator
	// Mid-run reset with EEPROM loading on: the strap is ignored and the bit loads once.
	task automatic t_eeprom;
		@(negedge clk);
		{srst, eload, ecap, strap} = 4'hf;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (6) @(negedge clk);
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("eeprom wait", 32'h0280_0000, q);
		cmp("cap waits", 32'h0, {31'h0, cap});
		edone = 1'b1;
		@(negedge clk);
		edone = 1'b0;
		ecap = 1'b0;
		@(negedge clk);
		cmp("cap loaded", 32'h1, {31'h0, cap});
		edone = 1'b1;
		@(negedge clk);
		edone = 1'b0;
		host_u.acc(1'b0, PCCS_CS_OFFSET, 32'h0, q);
		cmp("eeprom once", 32'h0290_0000, q);
	endtask : t_eeprom
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		{srst, sel, a_err, d_err, m_err, req, mhit, ihit} = 8'h80;
		{eload, ecap, edone, strap} = 4'h1;
		perr_n = 1'b1;
		repeat (10) @(negedge clk);
		srst = 1'b0;
		{req, mhit, ihit} = 3'h7;
		repeat (10) @(negedge clk);
		t_reset();
		t_claims(32'h0000_0007);
		t_claims(32'h0000_0002);
		t_claims(32'h0000_0000);
		t_parity();
		t_initiator();
		t_eeprom();
		final_report();
	end
endmodule : testbench
`default_nettype wire
